// *** verilog/fsd_decode.v ***
// Decode and issue logic for floating-point store instructions
`timescale 1ns/1ps
`include "fsd_map.vh"

module fsd_decode #(
  parameter AW          = 32,
  parameter HAS_INT_WORD = 1
) (
  input  wire          clk_sys,
  input  wire          rst_n,
  input  wire          instr_valid,
  input  wire [31:0]   instr_word,
  input  wire [AW-1:0] base_reg_val,
  input  wire [AW-1:0] index_reg_val,
  input  wire [63:0]   src_float_val,
  input  wire          src_single_tainted,
  input  wire          mem_done,
  input  wire          mem_align_fault,
  input  wire          mem_storage_fault,
  output reg           busy,
  output reg  [4:0]    src_float_reg,
  output reg  [4:0]    base_reg,
  output reg  [4:0]    index_reg,
  output reg           illegal_instr,
  output reg           mem_req,
  output reg  [AW-1:0] effective_address,
  output reg  [63:0]   mem_wdata,
  output reg  [1:0]    mem_size,
  output reg           mem_data_undefined,
  output reg           base_wr_en,
  output reg  [4:0]    base_wr_idx,
  output reg  [AW-1:0] base_wr_data,
  output reg           fpscr_wr_en,
  output reg           cr0_wr_en
);

  // Sequencer states
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  // Word bit n (big-endian numbering) is vector bit 31-n
  wire [5:0]  op     = instr_word[`FSD_OP_HI:`FSD_OP_LO];
  wire [4:0]  f_src  = instr_word[`FSD_SRC_HI:`FSD_SRC_LO];
  wire [4:0]  f_base = instr_word[`FSD_BASE_HI:`FSD_BASE_LO];
  wire [4:0]  f_idx  = instr_word[`FSD_INDEX_HI:`FSD_INDEX_LO];
  wire [9:0]  xo     = instr_word[`FSD_XO_HI:`FSD_XO_LO];
  wire [15:0] disp   = instr_word[`FSD_DISP_HI:`FSD_DISP_LO];

  // Shared primary opcode with one extended code
  function ext_match;
    input [5:0] opc;
    input [9:0] ext;
    input [9:0] code;
    begin
      ext_match = (opc == `FSD_OP_EXT) && (ext == code);
    end
  endfunction

  // Nonzero base field: base term and update allowed
  function base_used;
    input [4:0] fld;
    begin
      base_used = (fld != 5'h00);
    end
  endfunction

  // Sign-extend a 16-bit displacement to address width
  function [AW-1:0] sext16;
    input [15:0] d;
    begin
      sext16 = {{(AW-16){d[15]}}, d};
    end
  endfunction

  // Instruction classification; bit 0 never enters the match
  wire is_disp_upd = (op == `FSD_OP_DISP_UPD);
  wire is_idx_upd  = ext_match(op, xo, `FSD_XO_IDX_UPD);
  wire is_idx      = ext_match(op, xo, `FSD_XO_IDX);
  wire is_word_op  = ext_match(op, xo, `FSD_XO_INT_WORD);
  wire is_int_word = is_word_op && (HAS_INT_WORD != 0);
  wire is_int_off  = is_word_op && (HAS_INT_WORD == 0);
  wire is_update   = is_disp_upd | is_idx_upd;
  wire is_store    = is_update | is_idx | is_int_word;

  // Effective address; base field zero means no base term
  wire [AW-1:0] base_term = base_used(f_base) ? base_reg_val : {AW{1'b0}};
  wire [AW-1:0] disp_term = sext16(disp);
  wire [AW-1:0] addr_calc = is_disp_upd ? (base_term + disp_term)
                                        : (base_term + index_reg_val);

  // Store data; word form keeps the low half unconverted
  wire [63:0] wdata_calc = is_int_word ? {32'h0, src_float_val[31:0]}
                                       : src_float_val;
  wire [1:0]  size_calc  = is_int_word ? `FSD_SIZE_WORD : `FSD_SIZE_DOUBLE;
  wire        undef_calc = is_int_word && src_single_tainted;
  wire        upd_calc   = is_update && base_used(f_base);
  wire        fault_any  = mem_align_fault || mem_storage_fault;

  // Sequencer state and pending update
  reg          state_reg;
  reg          state_next;
  reg          upd_pend_reg;
  reg          upd_pend_next;
  reg [4:0]    upd_idx_reg;
  reg [4:0]    upd_idx_next;

  // Next values of the registered outputs
  reg          busy_next;
  reg [4:0]    src_next;
  reg [4:0]    base_next;
  reg [4:0]    index_next;
  reg          illegal_next;
  reg          req_next;
  reg [AW-1:0] addr_next;
  reg [63:0]   wdata_next;
  reg [1:0]    size_next;
  reg          undef_next;
  reg          bw_en_next;
  reg [4:0]    bw_idx_next;
  reg [AW-1:0] bw_data_next;

  // Issue, wait for memory, then conditional base update
  always @* begin
    state_next    = state_reg;
    upd_pend_next = upd_pend_reg;
    upd_idx_next  = upd_idx_reg;
    busy_next     = busy;
    src_next      = src_float_reg;
    base_next     = base_reg;
    index_next    = index_reg;
    addr_next     = effective_address;
    wdata_next    = mem_wdata;
    size_next     = mem_size;
    undef_next    = mem_data_undefined;
    bw_idx_next   = base_wr_idx;
    bw_data_next  = base_wr_data;
    req_next      = 1'b0;
    bw_en_next    = 1'b0;
    illegal_next  = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (instr_valid && is_int_off) begin
          illegal_next = 1'b1;
        end else if (instr_valid && is_store) begin
          src_next      = f_src;
          base_next     = f_base;
          index_next    = f_idx;
          addr_next     = addr_calc;
          wdata_next    = wdata_calc;
          size_next     = size_calc;
          undef_next    = undef_calc;
          upd_pend_next = upd_calc;
          upd_idx_next  = f_base;
          req_next      = 1'b1;
          busy_next     = 1'b1;
          state_next    = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (mem_done) begin
          busy_next     = 1'b0;
          state_next    = ST_IDLE;
          upd_pend_next = 1'b0;
          if (upd_pend_reg && !fault_any) begin
            bw_en_next   = 1'b1;
            bw_idx_next  = upd_idx_reg;
            bw_data_next = effective_address;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
        busy_next  = 1'b0;
      end
    endcase
  end

  // Sequencer registers
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= ST_IDLE;
      upd_pend_reg <= 1'b0;
      upd_idx_reg  <= 5'h00;
    end else begin
      state_reg    <= state_next;
      upd_pend_reg <= upd_pend_next;
      upd_idx_reg  <= upd_idx_next;
    end
  end

  // Output registers; status write enables stay low
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy               <= 1'b0;
      src_float_reg      <= 5'h00;
      base_reg           <= 5'h00;
      index_reg          <= 5'h00;
      illegal_instr      <= 1'b0;
      mem_req            <= 1'b0;
      effective_address  <= {AW{1'b0}};
      mem_wdata          <= 64'h0;
      mem_size           <= 2'h0;
      mem_data_undefined <= 1'b0;
      base_wr_en         <= 1'b0;
      base_wr_idx        <= 5'h00;
      base_wr_data       <= {AW{1'b0}};
      fpscr_wr_en        <= 1'b0;
      cr0_wr_en          <= 1'b0;
    end else begin
      busy               <= busy_next;
      src_float_reg      <= src_next;
      base_reg           <= base_next;
      index_reg          <= index_next;
      illegal_instr      <= illegal_next;
      mem_req            <= req_next;
      effective_address  <= addr_next;
      mem_wdata          <= wdata_next;
      mem_size           <= size_next;
      mem_data_undefined <= undef_next;
      base_wr_en         <= bw_en_next;
      base_wr_idx        <= bw_idx_next;
      base_wr_data       <= bw_data_next;
      fpscr_wr_en        <= 1'b0;
      cr0_wr_en          <= 1'b0;
    end
  end

endmodule

// *** inc/fsd_map.vh ***
// Constants for the floating-point store decoder
// How it works
// - Opcode 55: displacement store double with update
// - Opcode 31/759: indexed store double with update
// - Opcode 31/727: indexed store double, no update
// - Opcode 31/983: store low 32 float bits
// - Displacement address: base plus sign-extended offset, or offset
// - Indexed address: base plus index, or index
// - Double stores write whole float register
// - Update base only if nonzero and no fault
// - Never touch float status or condition field
// - Integer-word store may be undefined after single ops
// - Integer-word store is an optional instruction
`ifndef FSD_MAP_VH
`define FSD_MAP_VH
`define FSD_OP_DISP_UPD   6'h37
`define FSD_OP_EXT        6'h1f
`define FSD_XO_IDX_UPD    10'h2f7
`define FSD_XO_IDX        10'h2d7
`define FSD_XO_INT_WORD   10'h3d7
`define FSD_OP_HI         31
`define FSD_OP_LO         26
`define FSD_SRC_HI        25
`define FSD_SRC_LO        21
`define FSD_BASE_HI       20
`define FSD_BASE_LO       16
`define FSD_INDEX_HI      15
`define FSD_INDEX_LO      11
`define FSD_XO_HI         10
`define FSD_XO_LO         1
`define FSD_DISP_HI       15
`define FSD_DISP_LO       0
`define FSD_SIZE_WORD     2'h1
`define FSD_SIZE_DOUBLE   2'h2
`endif

// *** tb/fsd_decode_chk.sv ***
// Port checker for the float store decoder
`timescale 1ns/1ps
module fsd_chk #(
  parameter HAS_INT_WORD = 1
) (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        instr_valid,
  input wire logic        busy,
  input wire logic        mem_req,
  input wire logic        mem_done,
  input wire logic        mem_align_fault,
  input wire logic        mem_storage_fault,
  input wire logic        base_wr_en,
  input wire logic        illegal_instr,
  input wire logic        fpscr_wr_en,
  input wire logic        cr0_wr_en,
  input wire logic [31:0] instr_word,
  input wire logic [4:0]  base_reg,
  input wire logic [1:0]  mem_size
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Issue conditions per opcode
  wire       tk = instr_valid && !busy;
  wire       ex = tk && instr_word[31:26] == 6'h1f;
  wire [9:0] xo = instr_word[10:1];
  disp_issue_a: assert property (tk && instr_word[31:26] == 6'h37
    |=> mem_req && mem_size == 2'h2) else $error("disp store not issued");
  idx_upd_a: assert property (ex && xo == 10'h2f7 |=> mem_req && mem_size == 2'h2)
    else $error("indexed update store not issued");
  idx_plain_a: assert property (ex && xo == 10'h2d7 |=> mem_req && mem_size == 2'h2)
    else $error("indexed store not issued");
  word_issue_a: assert property (ex && xo == 10'h3d7 && HAS_INT_WORD != 0
    |=> mem_req && mem_size == 2'h1) else $error("word store not issued");
  word_gate_a: assert property (ex && xo == 10'h3d7 && HAS_INT_WORD == 0
    |=> illegal_instr && !mem_req) else $error("absent word store not refused");
  update_cause_a: assert property (base_wr_en |-> base_reg != 5'h0 && $past(mem_done)
    && !$past(mem_align_fault) && !$past(mem_storage_fault)) else $error("bad base update");
  req_pulse_a: assert property (mem_req |=> !mem_req && busy) else $error("request not a pulse");
  busy_end_a: assert property (busy && mem_done |=> !busy) else $error("busy stuck after done");
  status_quiet_a: assert property (!fpscr_wr_en && !cr0_wr_en)
    else $error("status written");
  cover property (base_wr_en);
  cover property (mem_done && mem_align_fault);
  cover property (mem_req && mem_size == 2'h1);
  cover property (illegal_instr);
endmodule

bind fsd_decode fsd_chk #(.HAS_INT_WORD(HAS_INT_WORD)) u_chk (.clk_sys(clk_sys),
  .rst_n(rst_n), .instr_valid(instr_valid),
  .busy(busy), .mem_req(mem_req), .mem_done(mem_done), .mem_align_fault(mem_align_fault),
  .mem_storage_fault(mem_storage_fault), .base_wr_en(base_wr_en),
  .illegal_instr(illegal_instr), .fpscr_wr_en(fpscr_wr_en),
  .cr0_wr_en(cr0_wr_en), .instr_word(instr_word), .base_reg(base_reg), .mem_size(mem_size));

// *** tb/fsd_mem_model.sv ***
// Load/store unit model answering each request after a set latency
`timescale 1ns/1ps
module fsd_mem_model (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       mem_req,
  input wire logic       fa,
  input wire logic       fs,
  input wire logic [3:0] lat,
  output logic           mem_done,
  output wire logic      mem_align_fault,
  output wire logic      mem_storage_fault
);
  logic [3:0] cnt_reg;
  // Fault lines carry meaning only with done
  assign mem_align_fault   = mem_done ? fa : ~fa;
  assign mem_storage_fault = mem_done ? fs : ~fs;
  // Latency counter, one done pulse per request
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n) begin
      cnt_reg  <= 4'h0;
      mem_done <= 1'b0;
    end else begin
      mem_done <= cnt_reg == 4'h1;
      cnt_reg  <= mem_req ? lat + 4'h1 : (cnt_reg != 4'h0 ? cnt_reg - 4'h1 : 4'h0);
    end
endmodule

// *** tb/fsd_decode_tb_top.sv ***
// Testbench for the float store decoder
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
module fsd_decode_tb_top;
  logic clk_sys = 0, rst_n = 0, iv = 0, tnt = 0, fa = 0, fs = 0;
  logic [31:0] iw = 0, bv = 0, xv = 0;
  logic [63:0] fv = 0, f = 64'h48656c6c6f20776f;
  logic [3:0] lat = 4'h3;
  int failures = 0, total_checks = 0;
  wire busy, req, done, maf, msf, und, bwe, ill, ill0;
  wire [4:0] src_q, base_q, idx_q, bwi;
  wire [31:0] addr, bwd;
  wire [63:0] wd;
  wire [1:0] sz;
  fsd_decode DUT (.clk_sys(clk_sys), .rst_n(rst_n), .instr_valid(iv), .instr_word(iw),
    .base_reg_val(bv), .index_reg_val(xv), .src_float_val(fv), .src_single_tainted(tnt),
    .mem_done(done), .mem_align_fault(maf), .mem_storage_fault(msf), .busy(busy),
    .src_float_reg(src_q), .base_reg(base_q), .index_reg(idx_q), .illegal_instr(ill),
    .mem_req(req), .effective_address(addr), .mem_wdata(wd), .mem_size(sz),
    .mem_data_undefined(und), .base_wr_en(bwe), .base_wr_idx(bwi), .base_wr_data(bwd),
    .fpscr_wr_en(), .cr0_wr_en());
  fsd_mem_model u_mem (.clk_sys(clk_sys), .rst_n(rst_n), .mem_req(req), .fa(fa), .fs(fs),
    .lat(lat), .mem_done(done), .mem_align_fault(maf), .mem_storage_fault(msf));
  // Twin without the optional word store, same stimulus and memory answers
  fsd_decode #(.HAS_INT_WORD(0)) DUT_NOINT (.clk_sys(clk_sys), .rst_n(rst_n),
    .instr_valid(iv), .instr_word(iw), .base_reg_val(bv), .index_reg_val(xv),
    .src_float_val(fv), .src_single_tainted(tnt), .mem_done(done), .mem_align_fault(maf),
    .mem_storage_fault(msf), .busy(), .src_float_reg(), .base_reg(), .index_reg(),
    .illegal_instr(ill0), .mem_req(), .effective_address(), .mem_wdata(), .mem_size(),
    .mem_data_undefined(), .base_wr_en(), .base_wr_idx(), .base_wr_data(),
    .fpscr_wr_en(), .cr0_wr_en());
  initial forever #2 clk_sys = ~clk_sys;
  // One store: issue, check access, wait for completion
  task automatic st(input logic [31:0] w, b, x, input logic t, input logic [31:0] e,
                    input logic [1:0] s, input logic u);
    int n;
    logic seen;
    iv = 1; iw = w; bv = b; xv = x; fv = f; tnt = t;
    @(negedge clk_sys);
    iv = 0;
    `CHK(req, 1'b1)
    `CHK(addr, e)
    `CHK(wd, s == 2'h1 ? {32'h0, f[31:0]} : f)
    `CHK(sz, s)
    `CHK(und, t && s == 2'h1)
    `CHK({src_q, base_q, idx_q}, w[25:11])
    `CHK({ill, ill0}, {1'b0, w[31:26] == 6'h1f && w[10:1] == 10'h3d7})
    n = 0; seen = 0;
    while (busy && n < 40) begin @(negedge clk_sys); n++; seen |= bwe; end
    `CHK(seen, u)
    if (u) `CHK({bwd, bwi}, {e, w[20:16]})
  endtask
  task t_disp;
    st({6'h37, 5'h6, 5'h4, 16'hfff8}, 32'h1000, 0, 0, 32'hff8, 2'h2, 1);
    st({6'h37, 5'h6, 5'h0, 16'h8000}, 32'h1000, 0, 0, 32'hffff8000, 2'h2, 0);
  endtask
  task t_index;
    lat = 4'h0;
    st({6'h1f, 5'h6, 5'h4, 5'h5, 10'h2f7, 1'b0}, 8, 32'h100, 0, 32'h108, 2'h2, 1);
    st({6'h1f, 5'h6, 5'h4, 5'h5, 10'h2d7, 1'b1}, 8, 32'h100, 1, 32'h108, 2'h2, 0);
    st({6'h1f, 5'h6, 5'h0, 5'h5, 10'h2f7, 1'b1}, 8, 32'h100, 0, 32'h100, 2'h2, 0);
  endtask
  task t_word_fault;
    st({6'h1f, 5'h6, 5'h0, 5'h5, 10'h3d7, 1'b0}, 0, 32'h20, 1, 32'h20, 2'h1, 0);
    fa = 1;
    st({6'h1f, 5'h6, 5'h4, 5'h5, 10'h2f7, 1'b0}, 8, 32'h10, 0, 32'h18, 2'h2, 0);
    fa = 0; fs = 1;
    st({6'h37, 5'h6, 5'h4, 16'h0010}, 32'h40, 0, 0, 32'h50, 2'h2, 0);
    fs = 0;
  endtask
  task conclude;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clk_sys);
    rst_n = 1;
    t_disp;
    t_index;
    t_word_fault;
    conclude;
  end
  // Watchdog
  initial begin #4000; failures++; conclude; end
endmodule
